// [wdsl_watchdog_sleep.sv]
// watchdog timer, prescaler and sleep entry/wake control with an apb register slave
//
// Notes on behaviour
// - watchdog counts on its own rc oscillator, independent of the system clock
// - expiry while awake raises a full device reset
// - expiry while asleep wakes the device, no reset
// - fuse enable clear keeps the watchdog disabled forever
// - without prescaler the time-out is nominally 18 ms
// - software may assign the shared prescaler, up to 1:128
// - clear and sleep instructions clear watchdog and its owned prescaler
// - every expiry clears the active-low time-out flag
// - crystal modes hold the watchdog clear until 1024 start-up periods end
// - sleep clears watchdog but keeps it counting, oscillator driver off
// - sleep clears power-down flag and sets time-out flag; power-up sets both
// - pins keep their level or high impedance throughout sleep
// - watchdog reset stays internal, master clear pin never driven low
// - master clear wake resets; watchdog or interrupt wake continues
// - enabled interrupts wake regardless of the global enable
// - the next instruction is prefetched while sleep executes
// - interrupt wake runs next instruction, then vectors to 0004h if enabled
// - watchdog is cleared on every watchdog or interrupt wake
// - sleep with an enabled flag already set acts as a no-operation
// - flag set during sleep completes sleep, then wakes at once
// - only clockless interrupt sources can wake the device
// - interrupt flags set on their event whatever the enables
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "wdsl_defines.svh"

module wdsl_watchdog_sleep
  import wdsl_pkg::*;
#(
  parameter int WDT_OSC_NS = `WDSL_WDT_OSC_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuses and dedicated watchdog oscillator
  input wire logic [7:0] config_word,
  input wire logic wdt_osc_clk,
  // processor core
  input wire wdsl_cpu_req_s cpu_req,
  input wire logic [7:0] irq_event,
  input wire logic [7:0] irq_flag_clr,
  input wire logic [7:0] irq_enable,
  output logic [7:0] irq_flag,
  output logic wdog_expiry_flag_n,
  output logic sleep_entered_flag_n,
  output logic device_reset,
  output logic wake_pulse,
  output logic vector_req,
  output logic [12:0] vector_addr,
  output logic prefetch_req,
  output logic osc_drive_en,
  // master clear pin
  input wire logic master_clear_pin_i,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe,
  // i/o port hold
  input wire wdsl_io_s io_in,
  output wdsl_io_s io_out
);

  localparam int WDT_TICKS_I = `WDSL_WDT_TIMEOUT_NS / WDT_OSC_NS;
  localparam logic [9:0] WDT_LAST = 10'(WDT_TICKS_I - 1);
  localparam logic [10:0] OST_LAST = 11'(`WDSL_OST_PERIODS - 1);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic logic [6:0] ratio_mask(input logic [2:0] n);
    ratio_mask = 7'((8'h01 << n) - 8'h01);
  endfunction

  logic [7:0] option_q;
  logic [31:0] prdata_q;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [6:0] pre_q;
  logic [9:0] wdt_q;
  logic [10:0] ost_q;
  logic [11:0] ost_chk_q;
  wdsl_state_e st_q;
  logic to_n_q, pd_n_q;
  logic [7:0] flag_q;
  logic reset_q, wake_q, vector_q, prefetch_q, cause_irq_q;
  wdsl_io_s io_q;

  logic wdt_en, prescaler_owner_sel, osc_tick, wdt_step, clr_req, expire;
  logic irq_pend, irq_wake, sleep_go, crystal, wake_go, master_clear_pin_wake;
  logic acc, mapped;
  wdsl_fosc_e fosc;

  assign wdt_en = config_word[`WDSL_CFG_WATCHDOG_FUSE_ENABLE_BIT];
  assign prescaler_owner_sel = option_q[`WDSL_OPT_PSA_BIT];
  assign fosc = wdsl_fosc_e'(config_word[`WDSL_CFG_FOSC_LSB +: 3]);
  assign crystal = (fosc == WDSL_FOSC_LP) || (fosc == WDSL_FOSC_XT) || (fosc == WDSL_FOSC_HS);
  assign irq_pend = |(flag_q & irq_enable);
  assign irq_wake = |(flag_q & irq_enable & `WDSL_WAKE_MASK);
  assign sleep_go = cpu_req.sleep && (st_q == WDSL_AWAKE) && !irq_pend;
  assign master_clear_pin_wake = (st_q == WDSL_ASLEEP) && !master_clear_pin_i;
  assign wake_go = (st_q == WDSL_ASLEEP) && (expire || irq_wake);

  // apb: answer in the first access cycle, read data captured in setup
  assign acc = psel && penable;
  assign mapped = reg_hit(paddr, `WDSL_OFS_OPTION) || reg_hit(paddr, `WDSL_OFS_CONFIG) ||
                  reg_hit(paddr, `WDSL_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (reg_hit(paddr, `WDSL_OFS_OPTION)) begin
        prdata_q <= {24'h000000, option_q};
      end else if (reg_hit(paddr, `WDSL_OFS_CONFIG)) begin
        prdata_q <= {24'h000000, config_word};
      end else if (reg_hit(paddr, `WDSL_OFS_STATUS)) begin
        prdata_q <= {26'h0000000, st_q, osc_drive_en, irq_pend, pd_n_q, to_n_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= `WDSL_OPT_RESET;
    end else if (acc && pwrite && reg_hit(paddr, `WDSL_OFS_OPTION)) begin
      option_q <= pwdata[7:0];
    end
  end

  // watchdog oscillator edges are brought into pclk; the rising edge is taken between the second and third stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= wdt_osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  assign osc_tick = osc_s2_q && !osc_s3_q;

  // clear sources: instruction, sleep, wake, start-up hold, fuse off
  assign clr_req = (cpu_req.watchdog_clear_instr && st_q == WDSL_AWAKE) || sleep_go || wake_go ||
                   (st_q == WDSL_OST_WAIT) || !wdt_en;
  assign wdt_step = osc_tick && (!prescaler_owner_sel ||
                    ((pre_q & ratio_mask(option_q[`WDSL_OPT_PS_LSB +: 3])) ==
                     ratio_mask(option_q[`WDSL_OPT_PS_LSB +: 3])));
  assign expire = wdt_en && wdt_step && (wdt_q == WDT_LAST) && (st_q != WDSL_OST_WAIT);

  // prescaler only advances while the watchdog owns it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 7'h00;
    end else if (!prescaler_owner_sel || clr_req) begin
      pre_q <= 7'h00;
    end else if (osc_tick) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // keeps counting through sleep: only the oscillator tick drives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q <= 10'h000;
    end else if (clr_req || expire) begin
      wdt_q <= 10'h000;
    end else if (wdt_step) begin
      wdt_q <= wdt_q + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= WDSL_AWAKE;
      ost_q <= 11'h000;
    end else begin
      case (st_q)
        WDSL_AWAKE: begin
          if (sleep_go) begin
            st_q <= WDSL_ASLEEP;
          end
        end
        WDSL_ASLEEP: begin
          ost_q <= 11'h000;
          if (master_clear_pin_wake) begin
            st_q <= WDSL_AWAKE;
          end else if (wake_go) begin
            st_q <= crystal ? WDSL_OST_WAIT : WDSL_AWAKE;
          end
        end
        WDSL_OST_WAIT: begin
          ost_q <= ost_q + 11'h001;
          if (ost_q == OST_LAST || !master_clear_pin_i) begin
            st_q <= WDSL_AWAKE;
          end
        end
        default: begin
          st_q <= WDSL_AWAKE;
        end
      endcase
    end
  end
  assign osc_drive_en = (st_q != WDSL_ASLEEP);

  // status flags: power-up sets both, expiry clears time-out last so it wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end else begin
      if (sleep_go) begin
        pd_n_q <= 1'b0;
        to_n_q <= 1'b1;
      end
      if (expire) begin
        to_n_q <= 1'b0;
      end
    end
  end
  assign wdog_expiry_flag_n = to_n_q;
  assign sleep_entered_flag_n = pd_n_q;

  // an event in the cycle of its clear is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 8'h00;
    end else begin
      flag_q <= (flag_q & ~irq_flag_clr) | irq_event;
    end
  end
  assign irq_flag = flag_q;

  // reset, wake, vector and prefetch pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_q <= 1'b0;
      wake_q <= 1'b0;
      vector_q <= 1'b0;
      prefetch_q <= 1'b0;
      cause_irq_q <= 1'b0;
    end else begin
      reset_q <= (expire && st_q == WDSL_AWAKE) || master_clear_pin_wake;
      prefetch_q <= cpu_req.sleep && st_q == WDSL_AWAKE;
      if (wake_go) begin
        cause_irq_q <= irq_wake && !expire;
      end
      // continuation: resume once the clock is back
      if ((wake_go && !crystal) || (st_q == WDSL_OST_WAIT && ost_q == OST_LAST)) begin
        wake_q <= 1'b1;
        vector_q <= cpu_req.global_irq_enable && (wake_go ? (irq_wake && !expire) : cause_irq_q);
      end else begin
        wake_q <= 1'b0;
        vector_q <= 1'b0;
      end
    end
  end
  assign device_reset = reset_q;
  assign wake_pulse = wake_q;
  assign vector_req = vector_q;
  assign vector_addr = `WDSL_IRQ_VECTOR;
  assign prefetch_req = prefetch_q;

  // a watchdog reset never reaches the pin
  assign master_clear_pin_o = 1'b0;
  assign master_clear_pin_oe = 1'b0;

  // pins are frozen from the cycle sleep starts until the wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_q <= '0;
    end else if (st_q != WDSL_ASLEEP && !sleep_go) begin
      io_q <= io_in;
    end
  end
  assign io_out = io_q;

  wdt_reset_awake_a: assert property (@(posedge pclk) disable iff (!presetn)
    expire && st_q == WDSL_AWAKE |=> device_reset && !wake_pulse)
    else $error("expiry while awake gave no device reset");

  wdt_wake_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    expire && st_q == WDSL_ASLEEP && master_clear_pin_i |=> !device_reset && st_q != WDSL_ASLEEP)
    else $error("expiry in sleep did not wake without reset");

  fuse_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wdt_en |=> wdt_q == 10'h000 && !expire)
    else $error("disabled watchdog is counting");

  expiry_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    expire |=> !wdog_expiry_flag_n)
    else $error("expiry left the time-out flag set");

  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go |=> !sleep_entered_flag_n && wdog_expiry_flag_n && !osc_drive_en && wdt_q == 10'h000)
    else $error("sleep entry flags or watchdog wrong");

  sleep_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_req.sleep && irq_pend && st_q == WDSL_AWAKE && !expire
    |=> $stable(sleep_entered_flag_n) && $stable(wdog_expiry_flag_n) && st_q == WDSL_AWAKE)
    else $error("sleep with pending interrupt was not a no-operation");

  // separate count of the start-up hold, so its bound does not trust the state machine's own counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_chk_q <= 12'h000;
    end else if (st_q == WDSL_OST_WAIT) begin
      ost_chk_q <= ost_chk_q + 12'h001;
    end else begin
      ost_chk_q <= 12'h000;
    end
  end

  ost_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == WDSL_OST_WAIT |-> wdt_q == 10'h000 && ost_chk_q < 12'(`WDSL_OST_PERIODS))
    else $error("start-up hold not bounded or watchdog not held");

  irq_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == WDSL_ASLEEP && irq_wake |=> st_q != WDSL_ASLEEP)
    else $error("enabled interrupt did not wake");

  io_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == WDSL_ASLEEP && $past(st_q) == WDSL_ASLEEP |-> $stable(io_out))
    else $error("pins changed during sleep");

  pin_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    device_reset |-> !master_clear_pin_oe)
    else $error("master clear pin driven");

  flag_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_event[0] && irq_flag_clr[0] |=> irq_flag[0])
    else $error("interrupt event lost against clear");

endmodule

// [wdsl_defines.svh]
// register map, field positions, reset values and timing counts of the watchdog/sleep block
`ifndef WDSL_DEFINES_SVH
`define WDSL_DEFINES_SVH

// apb byte offsets
`define WDSL_OFS_OPTION 8'h00
`define WDSL_OFS_CONFIG 8'h04
`define WDSL_OFS_STATUS 8'h08

// option register fields
`define WDSL_OPT_RESET 8'hFF
`define WDSL_OPT_PSA_BIT 3
`define WDSL_OPT_PS_LSB 0

// configuration word fields
`define WDSL_CFG_WATCHDOG_FUSE_ENABLE_BIT 3
`define WDSL_CFG_FOSC_LSB 0

// status register fields
`define WDSL_ST_TO_BIT 0
`define WDSL_ST_PD_BIT 1
`define WDSL_ST_PEND_BIT 2
`define WDSL_ST_OSC_BIT 3
`define WDSL_ST_STATE_LSB 4

// interrupt sources able to wake without an on-chip clock
`define WDSL_WAKE_MASK 8'h7B
`define WDSL_IRQ_VECTOR 13'h0004

// timing
`define WDSL_CLK_NS 100
`define WDSL_WDT_TIMEOUT_NS 18000000
`define WDSL_WDT_OSC_NS 31250
`define WDSL_OST_PERIODS 1024

`endif

// [wdsl_pkg.sv]
// types shared by the watchdog/sleep block and its users
package wdsl_pkg;

  // gray along awake -> asleep -> oscillator start-up; start-up -> awake changes both bits
  typedef enum logic [1:0] {
    WDSL_AWAKE = 2'b00,
    WDSL_ASLEEP = 2'b01,
    WDSL_OST_WAIT = 2'b11
  } wdsl_state_e;

  typedef enum logic [2:0] {
    WDSL_FOSC_LP = 3'h0,
    WDSL_FOSC_XT = 3'h1,
    WDSL_FOSC_HS = 3'h2,
    WDSL_FOSC_EC = 3'h3,
    WDSL_FOSC_INTERNAL_RC_MODE_A = 3'h4,
    WDSL_FOSC_INTERNAL_RC_MODE_B = 3'h5,
    WDSL_FOSC_RC_A = 3'h6,
    WDSL_FOSC_RC_B = 3'h7
  } wdsl_fosc_e;

  typedef struct packed {
    logic watchdog_clear_instr;
    logic sleep;
    logic global_irq_enable;
  } wdsl_cpu_req_s;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } wdsl_io_s;

endpackage

// [wdsl_core_model.sv]
// processor core model that issues clear and sleep instructions
`timescale 1ns/1ps
module wdsl_core_model
  import wdsl_pkg::*;
(
  // clock
  input wire logic pclk,
  // instruction requests to the block
  output wdsl_cpu_req_s cpu_req
);
  initial cpu_req = '0;

  // one-cycle instruction pulse, s selects sleep over clear
  task automatic issue(input logic s);
    @(posedge pclk);
    cpu_req.sleep <= s;
    cpu_req.watchdog_clear_instr <= !s;
    @(posedge pclk);
    cpu_req.sleep <= 1'b0;
    cpu_req.watchdog_clear_instr <= 1'b0;
  endtask

  // clear first, so a sleep that degrades to a no-op still leaves the count fresh
  task automatic nap();
    issue(1'b0);
    issue(1'b1);
  endtask

  task automatic set_gie(input logic g);
    @(posedge pclk);
    cpu_req.global_irq_enable <= g;
  endtask
endmodule

// [wdsl_watchdog_sleep_tb.sv]
// self-checking bench of the watchdog and sleep control block
`timescale 1ns/1ps
`include "wdsl_defines.svh"
module wdsl_watchdog_sleep_tb
  import wdsl_pkg::*;
;
  // six ticks per time-out keeps the run short
  localparam int OSC_NS = 3000000;
  localparam int TICKS = 18000000 / OSC_NS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wdt_osc_clk;
  logic [7:0] paddr, config_word, irq_event, irq_flag_clr, irq_enable, irq_flag;
  logic [31:0] pwdata, prdata, rd;
  logic tmo_n, slp_n, dev_rst, wake, vec_req, prefetch, osc_en, pin_i, pin_o, pin_oe;
  logic [12:0] vec_addr;
  wdsl_cpu_req_s cpu_req;
  wdsl_io_s io_in, io_out;
  logic [7:0] opts [5] = '{8'h00, 8'h08, 8'h09, 8'h0A, 8'h0F};
  int mismatches = 0;
  int checks_done = 0;
  int n, t, g;

  wdsl_watchdog_sleep #(.WDT_OSC_NS(OSC_NS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_word(config_word), .wdt_osc_clk(wdt_osc_clk), .cpu_req(cpu_req),
    .irq_event(irq_event), .irq_flag_clr(irq_flag_clr), .irq_enable(irq_enable),
    .irq_flag(irq_flag), .wdog_expiry_flag_n(tmo_n), .sleep_entered_flag_n(slp_n),
    .device_reset(dev_rst), .wake_pulse(wake), .vector_req(vec_req),
    .vector_addr(vec_addr), .prefetch_req(prefetch), .osc_drive_en(osc_en),
    .master_clear_pin_i(pin_i), .master_clear_pin_o(pin_o),
    .master_clear_pin_oe(pin_oe), .io_in(io_in), .io_out(io_out)
  );
  wdsl_core_model core (.pclk(pclk), .cpu_req(cpu_req));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // free running and unrelated in phase to pclk
  initial begin
    wdt_osc_clk = 1'b0;
    #237;
    forever #500 wdt_osc_clk = ~wdt_osc_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      mismatches++;
      summarize();
    end
  endtask

  // k 0 waits for a reset pulse, 1 for a wake pulse; n counts cycles
  task automatic wait_sig(input int k, input int hi, input logic must);
    for (n = 0; n < hi; n++) begin
      @(negedge pclk);
      if ((k == 0 ? dev_rst : wake) === 1'b1) break;
    end
    if (must && n == hi) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic pulse_irq(input logic [7:0] ev, input logic [7:0] clr);
    @(posedge pclk);
    irq_event <= ev;
    irq_flag_clr <= clr;
    @(posedge pclk);
    irq_event <= 8'h00;
    irq_flag_clr <= 8'h00;
  endtask

  task automatic do_reset(input logic [7:0] cfg);
    @(posedge pclk);
    presetn <= 1'b0;
    config_word <= cfg;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    config_word = 8'h06;
    irq_event = 8'h00;
    irq_flag_clr = 8'h00;
    irq_enable = 8'h00;
    pin_i = 1'b1;
    io_in = '0;
    do_reset(8'h06);
    apb(1'b0, `WDSL_OFS_OPTION, 32'h0);
    check("option reset", rd, 32'hFF);
    apb(1'b1, `WDSL_OFS_CONFIG, 32'hFF);
    apb(1'b0, `WDSL_OFS_CONFIG, 32'h0);
    check("config", rd, 32'h06);
    apb(1'b0, `WDSL_OFS_STATUS, 32'h0);
    check("status reset", rd, 32'h0B);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped error", err, 1'b1);
    apb(1'b1, `WDSL_OFS_OPTION, 32'h0);
    wait_sig(0, 150, 1'b0);
    check("fuse off expiry", n, 150);
    do_reset(8'h0E);
    foreach (opts[i]) begin
      t = opts[i][3] ? TICKS << opts[i][2:0] : TICKS;
      apb(1'b1, `WDSL_OFS_OPTION, {24'h0, opts[i]});
      core.issue(1'b0);
      wait_sig(0, t * 10 + 8, 1'b1);
      check("expiry time", n >= (t - 1) * 10 - 2, 1'b1);
      check("timeout flag", tmo_n, 1'b0);
      check("pin enable", pin_oe, 1'b0);
    end
    apb(1'b1, `WDSL_OFS_OPTION, 32'h0);
    repeat (4) begin
      core.issue(1'b0);
      wait_sig(0, 40, 1'b0);
      check("cleared expiry", n, 40);
    end
    io_in <= '{8'hA5, 8'h3C};
    core.nap();
    @(negedge pclk);
    check("sleep flag", slp_n, 1'b0);
    check("timeout set", tmo_n, 1'b1);
    check("osc driver", osc_en, 1'b0);
    check("prefetch", prefetch, 1'b1);
    io_in <= '{8'h5A, 8'hC3};
    wait_sig(1, TICKS * 10 + 8, 1'b1);
    check("sleep expiry time", n >= (TICKS - 1) * 10 - 4, 1'b1);
    check("io hold", io_out, 16'hA53C);
    check("wake no reset", dev_rst, 1'b0);
    check("wake timeout", tmo_n, 1'b0);
    wait_sig(0, 45, 1'b0);
    check("wake clears", n, 45);
    check("io release", io_out, 16'h5AC3);
    irq_enable <= 8'h05;
    for (g = 0; g < 2; g++) begin
      core.set_gie(g[0]);
      core.nap();
      pulse_irq(8'h06, 8'h00);
      wait_sig(1, 10, 1'b0);
      check("no wake", n, 10);
      check("flags", irq_flag, 8'h06);
      pulse_irq(8'h01, 8'h00);
      wait_sig(1, 6, 1'b1);
      check("vector req", vec_req, g[0]);
      check("vector", vec_addr, 13'h0004);
      pulse_irq(8'h00, 8'hFF);
    end
    // fresh power-up so the power-down flag starts set and a no-op is visible on it
    do_reset(8'h0E);
    pulse_irq(8'h01, 8'h00);
    core.nap();
    @(negedge pclk);
    check("noop sleep flag", slp_n, 1'b1);
    check("noop osc", osc_en, 1'b1);
    pulse_irq(8'h00, 8'hFF);
    core.nap();
    pulse_irq(8'h01, 8'h00);
    wait_sig(1, 6, 1'b1);
    check("late flag sleep", slp_n, 1'b0);
    pulse_irq(8'h00, 8'hFF);
    core.nap();
    pin_i <= 1'b0;
    wait_sig(0, 5, 1'b1);
    pin_i <= 1'b1;
    check("pin wake reset", dev_rst, 1'b1);
    do_reset(8'h09);
    irq_enable <= 8'h01;
    core.nap();
    pulse_irq(8'h01, 8'h00);
    wait_sig(1, 1100, 1'b1);
    check("startup wait", n >= 1020, 1'b1);
    summarize();
  end
endmodule
